/* File: logic/tsc_slot_bank.sv */
// Purpose: slot configuration registers and serial output serializer
// Assumes: bit clock and frame sync sampled by the system clock
// Notes: 32-bit slots, launch on falling bit clock, frame starts on sync rise
`timescale 1ns/10ps
module tsc_slot_bank
  import tsc_pkg::*;
(
  input wire logic clock,
  input wire logic rstn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic bit_clk,
  input wire logic frame_sync,
  input wire logic [15:0] voltage_sense_word,
  input wire logic [15:0] current_sense_word,
  input wire logic [11:0] low_rail_level,
  input wire logic [11:0] high_rail_level,
  input wire logic [11:0] temp_level,
  input wire logic high_rail_undervoltage,
  input wire logic overcurrent_flag,
  input wire logic over_temp_flag,
  input wire logic power_threshold_one,
  input wire logic power_threshold_two,
  input wire logic brownout_flag,
  input wire logic limiter_attenuating,
  input wire logic noise_gate_mode,
  input wire logic high_rail_connected,
  input wire logic device_active,
  output logic serial_out_line_o,
  output logic serial_out_line_oe_n,
  output logic supply_track_resolution,
  output logic [2:0] low_side_overcurrent_trim,
  output logic [2:0] interchip_pin_function
);
  logic [7:0] vsense_q, isense_q, mon_q, stat_q, aux_q, txctl_q;
  logic [31:0] prdata_q;
  logic bclk_s1_q, bclk_s2_q, bclk_s3_q, fs_s1_q, fs_s2_q, fs_s3_q;
  logic [4:0] bit_q;
  logic [5:0] slot_q;
  logic [1:0] mon_idx_q;
  logic mon_rep_q;
  logic sdo_q, sdo_oe_n_q;

  wire [9:0] word_idx = paddr[11:2];
  wire wr_go = psel && penable && pwrite;
  wire rd_go = psel && penable && !pwrite;
  wire hit_v = word_idx == {2'b00, IDX_VSENSE};
  wire hit_i = word_idx == {2'b00, IDX_ISENSE};
  wire hit_m = word_idx == {2'b00, IDX_MON};
  wire hit_s = word_idx == {2'b00, IDX_STAT};
  wire hit_a = word_idx == {2'b00, IDX_AUX};
  wire hit_t = word_idx == {2'b00, IDX_TXCTL};
  wire hit_any = hit_v || hit_i || hit_m || hit_s || hit_a || hit_t;
  wire [7:0] rd_mux = hit_v ? vsense_q : hit_i ? isense_q : hit_m ? mon_q :
                      hit_s ? stat_q : hit_a ? aux_q : hit_t ? txctl_q : 8'h00;

  // Zero wait state; unmapped words answer with an error
  assign pready = 1'b1;
  assign pslverr = psel && penable && !hit_any;
  assign prdata = prdata_q;

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      vsense_q <= RST_VSENSE;
      isense_q <= RST_ISENSE;
      mon_q <= RST_MON;
      stat_q <= RST_STAT;
      aux_q <= RST_AUX;
      txctl_q <= RST_TXCTL;
    end else if (wr_go) begin
      if (hit_v) vsense_q <= pwdata[7:0];
      if (hit_i) isense_q <= pwdata[7:0] & MASK_ISENSE;
      if (hit_m) mon_q <= pwdata[7:0];
      if (hit_s) stat_q <= pwdata[7:0];
      if (hit_a) aux_q <= pwdata[7:0] & MASK_AUX;
      if (hit_t) txctl_q <= {6'h00, pwdata[1:0]};
    end
  end

  // Read data registered during setup so it is stable in the access phase
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) prdata_q <= 32'h0000_0000;
    else if (psel && !penable && !pwrite) prdata_q <= {24'h000000, rd_mux};
  end

  assign supply_track_resolution = vsense_q[BIT_TOP];
  assign low_side_overcurrent_trim = aux_q[7:5];
  // Reserved codes fall back to buffers disabled, the safest pin state
  wire [2:0] icc_raw = aux_q[4:2];
  wire icc_ok = icc_raw == 3'h0 || icc_raw == 3'h2 || icc_raw == 3'h3 || icc_raw == 3'h4;
  assign interchip_pin_function = icc_ok ? icc_raw : 3'h2;

  // Link inputs: two flops; third bit clock flop finds edges, third sync
  // flop holds frame sync as seen at the last bit clock rise, because
  // sync settles well before the rise that opens the frame
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      bclk_s1_q <= 1'b0;
      bclk_s2_q <= 1'b0;
      bclk_s3_q <= 1'b0;
      fs_s1_q <= 1'b0;
      fs_s2_q <= 1'b0;
      fs_s3_q <= 1'b0;
    end else begin
      bclk_s1_q <= bit_clk;
      bclk_s2_q <= bclk_s1_q;
      bclk_s3_q <= bclk_s2_q;
      fs_s1_q <= frame_sync;
      fs_s2_q <= fs_s1_q;
      if (bclk_s2_q && !bclk_s3_q) fs_s3_q <= fs_s2_q;
    end
  end

  wire bclk_rise = bclk_s2_q && !bclk_s3_q;
  wire bclk_fall = !bclk_s2_q && bclk_s3_q;
  wire fs_seen = fs_s2_q;

  // Status byte with optional threshold swap
  wire bit5 = stat_q[BIT_TOP] ? (power_threshold_two | over_temp_flag) : over_temp_flag;
  wire bit6 = stat_q[BIT_TOP] ? power_threshold_one : overcurrent_flag;
  wire [7:0] status_byte = {high_rail_undervoltage, bit6, bit5,
                            brownout_flag, limiter_attenuating,
                            noise_gate_mode, high_rail_connected, device_active};

  // Monitor stream selection
  wire [11:0] mon_raw = mon_idx_q == TSC_MON_LOW ? low_rail_level :
                        mon_idx_q == TSC_MON_HIGH ? high_rail_level :
                        mon_idx_q == TSC_MON_TEMP ? temp_level : MARKER_WORD[15:4];
  wire [15:0] mon_word = mon_idx_q == TSC_MON_MARK ? MARKER_WORD : {mon_raw, 4'h0};
  wire mon_long = mon_q[BIT_TOP];
  wire [4:0] mon_bits = mon_long ? 5'd16 : 5'd8;

  // Which source owns the current bit
  wire v_on = vsense_q[BIT_EN] && slot_q == vsense_q[5:0] && bit_q < 5'd16;
  wire i_on = isense_q[BIT_EN] && slot_q == isense_q[5:0] && bit_q < 5'd16;
  wire m_on = mon_q[BIT_EN] && slot_q == mon_q[5:0] && bit_q < mon_bits;
  wire s_on = stat_q[BIT_EN] && slot_q == stat_q[5:0] && bit_q < 5'd8;
  wire [3:0] b16 = 4'd15 - bit_q[3:0];
  wire [2:0] b8 = 3'd7 - bit_q[2:0];
  wire mon_bit = mon_long ? mon_word[b16] : mon_word[4'd8 + {1'b0, b8}];
  wire data_on = v_on || i_on || m_on || s_on;
  wire data_bit = v_on ? voltage_sense_word[b16] : i_on ? current_sense_word[b16] :
                  m_on ? mon_bit : status_byte[b8];
  wire fill_z = txctl_q[TX_FILL_BIT];
  wire rate_192 = txctl_q[TX_RATE_BIT];
  wire frame_end = bclk_rise && fs_seen && !fs_s3_q;

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      bit_q <= 5'd0;
      slot_q <= 6'h00;
      mon_idx_q <= TSC_MON_LOW;
      mon_rep_q <= 1'b0;
    end else if (frame_end) begin
      bit_q <= 5'd0;
      slot_q <= 6'h00;
      if (mon_q[BIT_EN]) begin
        if (rate_192 && !mon_rep_q) begin
          mon_rep_q <= 1'b1;
        end else begin
          mon_rep_q <= 1'b0;
          mon_idx_q <= mon_idx_q + 2'd1;
        end
      end
    end else if (bclk_rise) begin
      bit_q <= bit_q + 5'd1;
      if (bit_q == 5'd31) slot_q <= slot_q + 6'h01;
    end
  end

  // Launch on falling bit clock; unused bits per fill setting
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      sdo_q <= 1'b0;
      sdo_oe_n_q <= 1'b1;
    end else if (bclk_fall) begin
      sdo_q <= data_on ? data_bit : 1'b0;
      sdo_oe_n_q <= !data_on && fill_z;
    end
  end

  assign serial_out_line_o = sdo_q;
  assign serial_out_line_oe_n = sdo_oe_n_q;

  a_vsense_reset: assert property (@(posedge clock) $rose(rstn) |-> vsense_q == RST_VSENSE
    && isense_q == RST_ISENSE) else $error("sense reset wrong");
  a_status_slot_def: assert property (@(posedge clock) $rose(rstn) |-> stat_q[5:0] == 6'h08)
    else $error("status slot default wrong");
  a_mon_slot_def: assert property (@(posedge clock) $rose(rstn) |-> mon_q == RST_MON)
    else $error("monitor default wrong");
  a_res_out: assert property (@(posedge clock) disable iff (!rstn)
    supply_track_resolution == vsense_q[7]) else $error("resolution wrong");
  a_swap_bits: assert property (@(posedge clock) disable iff (!rstn)
    stat_q[7] |-> status_byte[6] == power_threshold_one) else $error("swap wrong");
  a_status_map: assert property (@(posedge clock) disable iff (!rstn)
    status_byte[4:0] == {brownout_flag, limiter_attenuating, noise_gate_mode,
    high_rail_connected, device_active}) else $error("status map wrong");
  a_fill_float: assert property (@(posedge clock) disable iff (!rstn)
    bclk_fall && !data_on && fill_z |=> serial_out_line_oe_n) else $error("fill wrong");
  a_drive_data: assert property (@(posedge clock) disable iff (!rstn)
    bclk_fall && s_on && !v_on && !i_on && !m_on |=> !serial_out_line_oe_n
    && serial_out_line_o == $past(status_byte[b8])) else $error("status bit wrong");
  a_icc_legal: assert property (@(posedge clock) disable iff (!rstn)
    interchip_pin_function != 3'h1 && interchip_pin_function < 3'h5)
    else $error("icc reserved code");
  a_trim_write: assert property (@(posedge clock) disable iff (!rstn)
    wr_go && hit_a |=> low_side_overcurrent_trim == $past(pwdata[7:5]))
    else $error("trim write lost");
  a_isense_top: assert property (@(posedge clock) disable iff (!rstn)
    !isense_q[7]) else $error("reserved bit set");
  a_fill_zero: assert property (@(posedge clock) disable iff (!rstn)
    bclk_fall && !data_on && !fill_z |=> !serial_out_line_oe_n && !serial_out_line_o)
    else $error("zero fill wrong");
  a_mon_repeat: assert property (@(posedge clock) disable iff (!rstn)
    frame_end && mon_q[BIT_EN] && rate_192 && !mon_rep_q |=> mon_rep_q
    && $stable(mon_idx_q)) else $error("monitor repeat wrong");
  a_mon_step: assert property (@(posedge clock) disable iff (!rstn)
    frame_end && mon_q[BIT_EN] && !rate_192 |=> mon_idx_q == $past(mon_idx_q) + 2'd1)
    else $error("monitor order wrong");
  a_vsense_bit: assert property (@(posedge clock) disable iff (!rstn)
    bclk_fall && v_on |=> !serial_out_line_oe_n
    && serial_out_line_o == $past(voltage_sense_word[b16])) else $error("voltage bit wrong");
  a_frame_restart: assert property (@(posedge clock) disable iff (!rstn)
    frame_end |=> bit_q == 5'h00 && slot_q == 6'h00) else $error("frame start wrong");
endmodule : tsc_slot_bank

/* File: logic/tsc_pkg.sv */
// Purpose: constants for the serial-output slot configuration bank
// Assumes: APB slave, 32-bit data, printed offsets are register indices
// Notes: byte address is four times the index
// Summary of operation
// - Supply tracking resolution: 0=8 bits, 1=16
// - Voltage sense sent only when enabled
// - Voltage sense slot field, default slot 2
// - Current sense sent only when enabled
// - Current sense slot field, default slot 0
// - Monitor length: truncate 8 or justify 16
// - Monitor words sent only when enabled
// - Monitor slot field, default slot 4
// - 96k order: low, high, temp, marker
// - 192k order: each monitor item twice
// - Swap puts threshold one in bit 6, threshold two ORed with temperature in bit 5
// - Status byte sent only when enabled
// - Status slot field, default slot 8
// - Status bits 7,6,5: undervoltage, overcurrent, temperature
// - Status bit 4 brownout, bit 3 limiter
// - Bits 2,1,0: noise gate, high rail, active
// - Three-bit low-side overcurrent trim code
// - Three-bit interchip pin function, reserved codes
// - Unused bits drive zero or float
package tsc_pkg;
  localparam logic [7:0] IDX_VSENSE = 8'h0E;
  localparam logic [7:0] IDX_ISENSE = 8'h0F;
  localparam logic [7:0] IDX_MON = 8'h10;
  localparam logic [7:0] IDX_STAT = 8'h13;
  localparam logic [7:0] IDX_AUX = 8'h15;
  localparam logic [7:0] IDX_TXCTL = 8'h20;
  localparam logic [7:0] RST_VSENSE = 8'hC2;
  localparam logic [7:0] RST_ISENSE = 8'h40;
  localparam logic [7:0] RST_MON = 8'h04;
  localparam logic [7:0] RST_STAT = 8'h08;
  localparam logic [7:0] RST_AUX = 8'h00;
  localparam logic [7:0] RST_TXCTL = 8'h01;
  localparam logic [7:0] MASK_ISENSE = 8'h7F;
  localparam logic [7:0] MASK_AUX = 8'hFC;
  localparam int BIT_TOP = 7;
  localparam int BIT_EN = 6;
  localparam int TX_FILL_BIT = 0;
  localparam int TX_RATE_BIT = 1;
  localparam logic [5:0] SLOT_BITS = 6'h20;
  localparam logic [15:0] MARKER_WORD = 16'hA5A5;
  typedef enum logic [1:0] {
    TSC_MON_LOW = 2'b00,
    TSC_MON_HIGH = 2'b01,
    TSC_MON_TEMP = 2'b10,
    TSC_MON_MARK = 2'b11
  } tsc_mon_t;
endpackage : tsc_pkg

/* File: dv/tsc_host_model.sv */
// Purpose: host end of the serial output, makes bit clock and frame sync
// Assumes: 200 ns bit clock that stands still between frames
// Notes: a floating line is recorded as the inverse of the last value
`timescale 1ns/10ps
module tsc_host_model (
  output logic bit_clk,
  output logic frame_sync,
  input wire logic sdo,
  input wire logic sdo_oe_n
);
  logic [287:0] seen_d;
  logic [287:0] seen_z;
  logic last_v = 1'b0;
  initial begin
    bit_clk = 1'b0;
    frame_sync = 1'b0;
  end
  // Nine 32-bit slots; bit k is captured on rise k+1
  task automatic run_frame();
    for (int k = 0; k <= 288; k++) begin
      frame_sync = (k == 0);
      #100 bit_clk = 1'b1;
      if (k > 0) begin
        seen_z[k-1] = sdo_oe_n;
        last_v = sdo_oe_n ? ~last_v : sdo;
        seen_d[k-1] = last_v;
      end
      #100 bit_clk = 1'b0;
    end
  endtask : run_frame
endmodule : tsc_host_model

/* File: dv/testbench.sv */
// Purpose: self-checking bench for the slot configuration bank
// Assumes: zero-wait APB slave, host model drives the link
// Notes: monitor phase is learnt from the frames, not assumed
`timescale 1ns/10ps
`define CHK(nm, e, g) begin samples_checked++; if ((g) !== (e)) begin n_fail++; \
  $display("CHECK FAILED %s exp %0h got %0h", nm, e, g); end end
module testbench
  import tsc_pkg::*;
;
  logic clock = 1'b0, rstn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = 12'h000, lo_l = 12'h000, hi_l = 12'h000, tp_l = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rd, seed = 32'hFDA60E0B;
  logic pready, pslverr, sdo, sdo_oe_n, res, bit_clk, frame_sync, err;
  logic [15:0] vw = 16'h0, iw = 16'h0;
  logic [9:0] st = 10'h0;
  logic [2:0] trim, pfn;
  int n_fail = 0, samples_checked = 0, mi [9];
  logic [7:0] idx_t [6] = '{IDX_VSENSE, IDX_ISENSE, IDX_MON, IDX_STAT, IDX_AUX, IDX_TXCTL};
  logic [7:0] rst_t [6] = '{RST_VSENSE, RST_ISENSE, RST_MON, RST_STAT, RST_AUX, RST_TXCTL};
  always #12.5 clock = ~clock;
  tsc_slot_bank uut (.clock(clock), .rstn(rstn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .bit_clk(bit_clk), .frame_sync(frame_sync),
    .voltage_sense_word(vw), .current_sense_word(iw), .low_rail_level(lo_l),
    .high_rail_level(hi_l), .temp_level(tp_l), .high_rail_undervoltage(st[0]),
    .overcurrent_flag(st[1]), .over_temp_flag(st[2]), .power_threshold_one(st[3]),
    .power_threshold_two(st[4]), .brownout_flag(st[5]), .limiter_attenuating(st[6]),
    .noise_gate_mode(st[7]), .high_rail_connected(st[8]), .device_active(st[9]),
    .serial_out_line_o(sdo), .serial_out_line_oe_n(sdo_oe_n),
    .supply_track_resolution(res), .low_side_overcurrent_trim(trim),
    .interchip_pin_function(pfn));
  tsc_host_model host (.bit_clk(bit_clk), .frame_sync(frame_sync), .sdo(sdo),
    .sdo_oe_n(sdo_oe_n));
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : rnd
  function automatic logic [15:0] fld(int pos, int n);
    fld = 16'h0;
    for (int i = 0; i < n; i++) fld = {fld[14:0], host.seen_d[pos+i]};
  endfunction : fld
  function automatic logic [7:0] sexp(logic sw);
    return {st[0], sw ? st[3] : st[1], sw ? (st[4] | st[2]) : st[2], st[5], st[6], st[7],
      st[8], st[9]};
  endfunction : sexp
  function automatic logic [15:0] mexp(int i, logic l16);
    logic [15:0] w;
    w = (i == 0) ? {lo_l, 4'h0} : (i == 1) ? {hi_l, 4'h0} : (i == 2) ? {tp_l, 4'h0} : MARKER_WORD;
    return l16 ? w : {8'h00, w[15:8]};
  endfunction : mexp
  task automatic apb(input logic w, input logic [7:0] idx, input logic [31:0] wd);
    @(posedge clock);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= {2'b00, idx, 2'b00};
    pwdata <= wd;
    @(posedge clock);
    penable <= 1'b1;
    do @(posedge clock); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(negedge clock);
  endtask : apb
  task automatic frame(input logic fill, input logic sw, input logic l16, input logic se,
    output int m);
    @(posedge clock);
    vw <= 16'(rnd());
    iw <= 16'(rnd());
    st <= 10'(rnd());
    host.run_frame();
    `CHK("current", iw, fld(0, 16))
    `CHK("voltage", vw, fld(64, 16))
    `CHK("fill", {32{fill}}, host.seen_z[63:32])
    if (!fill) `CHK("zero", 32'h0, host.seen_d[63:32])
    if (se) `CHK("status", sexp(sw), fld(256, 8))
    else `CHK("status off", {8{fill}}, host.seen_z[263:256])
    m = 4;
    for (int i = 0; i < 4; i++) if (fld(128, l16 ? 16 : 8) === mexp(i, l16)) m = i;
  endtask : frame
  task automatic give_verdict();
    $display("checks %0d failures %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : give_verdict
  initial begin
    #2000000;
    n_fail++;
    give_verdict();
  end
  initial begin
    repeat (6) @(posedge clock);
    rstn <= 1'b1;
    lo_l <= 12'(rnd());
    hi_l <= 12'(rnd());
    tp_l <= 12'(rnd());
    `CHK("res reset", 1'b1, res)
    for (int i = 0; i < 6; i++) begin
      apb(1'b0, idx_t[i], 32'h0);
      `CHK("reset value", {24'h0, rst_t[i]}, rd)
    end
    apb(1'b0, 8'h11, 32'h0);
    `CHK("unmapped", 33'h100000000, {err, rd})
    apb(1'b1, IDX_ISENSE, 32'hFF);
    apb(1'b0, IDX_ISENSE, 32'h0);
    `CHK("reserved", 32'h7F, rd)
    apb(1'b1, IDX_ISENSE, 32'h40);
    apb(1'b1, IDX_VSENSE, 32'h42);
    `CHK("res low", 1'b0, res)
    apb(1'b1, IDX_VSENSE, 32'hC2);
    for (int c = 0; c < 8; c++) begin
      apb(1'b1, IDX_AUX, {24'h0, 3'(c), 3'(c), 2'b11});
      `CHK("trim", 3'(c), trim)
      `CHK("pin func", (c == 1 || c > 4) ? 3'd2 : 3'(c), pfn)
    end
    frame(1'b1, 1'b0, 1'b1, 1'b0, mi[0]);
    `CHK("mon off", 16'hFFFF, host.seen_z[143:128])
    apb(1'b1, IDX_MON, 32'hC4);
    apb(1'b1, IDX_STAT, 32'h48);
    apb(1'b1, IDX_TXCTL, 32'h00);
    for (int f = 0; f < 5; f++) frame(1'b0, 1'b0, 1'b1, 1'b1, mi[f]);
    for (int f = 0; f < 4; f++) `CHK("order 96k", (mi[f] + 1) % 4, mi[f+1])
    apb(1'b1, IDX_TXCTL, 32'h02);
    for (int f = 0; f < 9; f++) frame(1'b0, 1'b0, 1'b1, 1'b1, mi[f]);
    for (int f = 1; f < 7; f++) `CHK("order 192k", (mi[f] + 1) % 4, mi[f+2])
    apb(1'b1, IDX_MON, 32'h44);
    apb(1'b1, IDX_STAT, 32'hC8);
    apb(1'b1, IDX_TXCTL, 32'h01);
    for (int f = 0; f < 2; f++) begin
      frame(1'b1, 1'b1, 1'b0, 1'b1, mi[f]);
      `CHK("mon 8 bit", 1'b1, mi[f] < 4)
    end
    give_verdict();
  end
endmodule : testbench
